// ---- atatf_consts.vh ----
`ifndef ATATF_CONSTS_VH
`define ATATF_CONSTS_VH

// Register select codes addr[2:0]; command and control blocks reuse 6 and 7
`define ATATF_A_DATA       3'h0
`define ATATF_A_ERRFEAT    3'h1
`define ATATF_A_SECCNT     3'h2
`define ATATF_A_SECNUM     3'h3
`define ATATF_A_CYLLO      3'h4
`define ATATF_A_CYLHI      3'h5
`define ATATF_A_DEVHEAD    3'h6
`define ATATF_A_STATCMD    3'h7
`define ATATF_A_ALTCTL     3'h6
`define ATATF_A_DEVADDR    3'h7

// Device control fields
`define ATATF_DC_SOFT_RESET_BIT      2
`define ATATF_DC_NIEN      1
// Device/head fields
`define ATATF_DH_LBA       6
`define ATATF_DH_DEV       4
// Status fields
`define ATATF_ST_BSY       7
`define ATATF_ST_DRDY      6
`define ATATF_ST_DRQ       3
`define ATATF_ST_CORRECTED_DATA_FLAG      2
`define ATATF_ST_ERR       0

// Reset values
`define ATATF_RST_DEVHEAD  8'hA0
`define ATATF_RST_SECCNT   8'h01
`define ATATF_RST_SECNUM   8'h01
`define ATATF_RST_DEVCTL   8'h08

// Command codes and power mode answer
`define ATATF_CMD_CHKPWR   8'hE5
`define ATATF_PWR_IDLE     8'hFF

// Timing
`define ATATF_CLK_MHZ      200
`define ATATF_SOFT_RESET_BIT_MIN_US  5
`define ATATF_SOFT_RESET_BIT_CYC     (`ATATF_SOFT_RESET_BIT_MIN_US * `ATATF_CLK_MHZ)

`endif

// ---- atatf_buf_mem.v ----
`timescale 1ns/1ps
`default_nettype none
module atatf_buf_mem #(
  parameter AW = 8,
  parameter DW = 16
) (
  input  wire          ref_clk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // atatf_buf_mem
`default_nettype wire

// ---- atatf_strobe_edge.v ----
`timescale 1ns/1ps
`default_nettype none
// Turns level strobes into one-cycle pulses at their leading edge
module atatf_strobe_edge (
  input  wire ref_clk,
  input  wire rst,
  input  wire rd_n,
  input  wire wr_n,
  output reg  rd_pulse,
  output reg  wr_pulse
);
  reg rd_q_r;
  reg wr_q_r;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_q_r   <= 1'b1;
      wr_q_r   <= 1'b1;
      rd_pulse <= 1'b0;
      wr_pulse <= 1'b0;
    end else begin
      rd_q_r   <= rd_n;
      wr_q_r   <= wr_n;
      rd_pulse <= rd_q_r & ~rd_n;
      wr_pulse <= wr_q_r & ~wr_n;
    end
  end
endmodule // atatf_strobe_edge
`default_nettype wire

// ---- atatf_port.v ----
// Functional notes
// [R1] Strobes go to register picked by two chip selects and three address lines.
// [R2] Control block: 111 reads device address, 110 alt status / device control.
// [R3] Command block 0..7: data, error/features, count, number, cyl lo/hi, dev/head, status/cmd.
// [R4] Alternate status equals status and never acknowledges the interrupt.
// [R5] Command write launches execution at once.
// [R6] Host loads parameter registers before writing the command.
// [R7] CHS mode: cylinder registers rewritten with current cylinder at command end.
// [R8] LBA mode: cylinder high gets current LBA 23:16 at command end.
// [R9] LBA mode: cylinder low gets current LBA 15:8 at command end.
// [R10] Data transfers 16 bits; ECC bytes 8 bits.
// [R11] Data register is PIO only, no DMA path.
// [R12] Data valid only while data request flag is one.
// [R13] Data carries sector buffer, format layout and identify block.
// [R14] Device control bit 2 holds device in reset while one.
// [R15] Host holds soft reset bit at least 5 us.
// [R16] Interrupt enabled only with disable bit zero and device selected.
// [R17] Check power mode in idle returns FFh in sector count, never 80h.
// [R18] Hard reset response may differ from power-on response.
// [R19] Primary status read acknowledges and clears pending interrupt.
// [R20] Device select bit picks device 0 or 1; gates interrupt enable.
// [R21] LBA bit picks CHS or LBA meaning of address registers.
// [R22] Data request flag is status bit 3, set when a word can move.
// [R23] Both chip selects asserted: reads undriven, writes dropped.
`include "atatf_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module atatf_port #(
  parameter DEV_ID   = 1'b0,
  parameter BUF_AW   = 8,
  parameter SOFT_RESET_BIT_CYC = `ATATF_SOFT_RESET_BIT_CYC
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        hard_rst,
  input  wire        cs_cmd_n,
  input  wire        cs_ctl_n,
  input  wire [2:0]  addr,
  input  wire        rd_n,
  input  wire        wr_n,
  input  wire [15:0] dd_in,
  output reg  [15:0] dd_out,
  output reg         dd_oe,
  output reg         intrq,
  output reg         cmd_start,
  output reg  [7:0]  cmd_code,
  output reg         in_reset,
  output reg         ecc_byte_mode,
  input  wire        cmd_done,
  input  wire        cmd_err,
  input  wire        cmd_idle,
  input  wire [15:0] cur_cyl,
  input  wire [27:0] cur_lba,
  input  wire [3:0]  cur_head,
  input  wire        xfer_req,
  input  wire        xfer_last,
  input  wire        xfer_dir_in,
  input  wire        ecc_byte,
  input  wire        core_wr_en,
  input  wire [BUF_AW-1:0] core_wr_addr,
  input  wire [15:0] core_wr_data,
  input  wire [BUF_AW-1:0] core_rd_addr,
  output wire [15:0] core_rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire       rd_p;
  wire       wr_p;
  wire       sel_cmd  = ~cs_cmd_n & cs_ctl_n; // [R1]
  wire       sel_ctl  = cs_cmd_n & ~cs_ctl_n; // [R1]
  wire       both_cs  = ~cs_cmd_n & ~cs_ctl_n; // [R23]
  reg        pend_r;
  reg  [7:0] feat_r;
  reg  [7:0] err_r;
  reg  [7:0] seccnt_r;
  reg  [7:0] secnum_r;
  reg  [7:0] cyllo_r;
  reg  [7:0] cylhi_r;
  reg  [7:0] devhead_r;
  reg  [7:0] devctl_r;
  reg        bsy_r;
  reg        drq_r;
  reg        errf_r;
  reg        drdy_r;
  reg  [BUF_AW-1:0] ptr_r;
  reg  [31:0] soft_reset_bit_cnt_r;
  reg         rd_act_r;
  wire [15:0] buf_rd;
  wire [7:0]  status = {bsy_r, drdy_r, 1'b0, 1'b1, drq_r, 1'b0, 1'b0, errf_r};
  wire        lba_mode = devhead_r[`ATATF_DH_LBA]; // [R21]
  wire        dev_sel  = (devhead_r[`ATATF_DH_DEV] == DEV_ID); // [R20]
  wire        soft_reset_bit     = devctl_r[`ATATF_DC_SOFT_RESET_BIT];

  atatf_strobe_edge u_edge (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .rd_n     (rd_n),
    .wr_n     (wr_n),
    .rd_pulse (rd_p),
    .wr_pulse (wr_p)
  );

  // Command-block register hit at the current address
  function atatf_hit;
    input [2:0] a;
    input [2:0] code;
    input       sel;
    begin
      atatf_hit = sel & (a == code);
    end
  endfunction

  // Host writes fill the buffer, core reads drain it; core fills for reads
  wire host_data_wr = wr_p & atatf_hit(addr, `ATATF_A_DATA, sel_cmd) & drq_r; // [R12]
  wire host_data_rd = rd_p & atatf_hit(addr, `ATATF_A_DATA, sel_cmd) & drq_r; // [R12]
  // Read pointer steps once the strobe ends, so the word holds while sampled
  wire rd_done      = rd_act_r & rd_n;

  atatf_buf_mem #(.AW(BUF_AW), .DW(16)) u_buf (
    .ref_clk (ref_clk),
    .wr_en   (host_data_wr | core_wr_en),
    .wr_addr (host_data_wr ? ptr_r : core_wr_addr),
    .wr_data (host_data_wr ? dd_in : core_wr_data),
    .rd_addr (host_data_wr | ~xfer_dir_in ? core_rd_addr : ptr_r),
    .rd_data (buf_rd)
  ); // [R13] [R11]

  assign core_rd_data = buf_rd;

  wire cmd_wr  = wr_p & atatf_hit(addr, `ATATF_A_STATCMD, sel_cmd) & ~bsy_r & ~in_reset;
  wire stat_rd = rd_p & atatf_hit(addr, `ATATF_A_STATCMD, sel_cmd);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, command launch and completion
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      devctl_r   <= `ATATF_RST_DEVCTL;
      soft_reset_bit_cnt_r <= 32'h0000_0000;
      in_reset   <= 1'b1;
    end else begin
      if (wr_p & sel_ctl & (addr == `ATATF_A_ALTCTL)) begin
        devctl_r <= {4'h0, 1'b1, dd_in[2:1], 1'b0}; // [R14] [R2]
      end
      // Held in reset while bit set or hard_rst high; released when both clear
      if (soft_reset_bit | hard_rst) begin
        in_reset   <= 1'b1; // [R14]
        soft_reset_bit_cnt_r <= soft_reset_bit_cnt_r + 32'h0000_0001;
      end else begin
        in_reset   <= 1'b0; // [R14]
        soft_reset_bit_cnt_r <= 32'h0000_0000;
      end
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      feat_r    <= 8'h00;
      err_r     <= 8'h01;
      seccnt_r  <= `ATATF_RST_SECCNT;
      secnum_r  <= `ATATF_RST_SECNUM;
      cyllo_r   <= 8'h00;
      cylhi_r   <= 8'h00;
      devhead_r <= `ATATF_RST_DEVHEAD;
      bsy_r     <= 1'b0;
      drq_r     <= 1'b0;
      errf_r    <= 1'b0;
      drdy_r    <= 1'b1;
      pend_r    <= 1'b0;
      ptr_r     <= {BUF_AW{1'b0}};
      cmd_start <= 1'b0;
      cmd_code  <= 8'h00;
      rd_act_r  <= 1'b0;
      ecc_byte_mode <= 1'b0;
    end else if (in_reset) begin
      // Soft or hard reset reloads power-on values, except device/head, features and command code
      err_r     <= 8'h01; // [R18]
      seccnt_r  <= `ATATF_RST_SECCNT;
      secnum_r  <= `ATATF_RST_SECNUM;
      cyllo_r   <= 8'h00;
      cylhi_r   <= 8'h00;
      bsy_r     <= 1'b0;
      drq_r     <= 1'b0;
      errf_r    <= 1'b0;
      pend_r    <= 1'b0;
      ptr_r     <= {BUF_AW{1'b0}};
      cmd_start <= 1'b0;
      ecc_byte_mode <= 1'b0;
      rd_act_r  <= 1'b0;
    end else begin
      cmd_start     <= 1'b0;
      ecc_byte_mode <= ecc_byte; // [R10]
      if (host_data_rd) begin
        rd_act_r <= 1'b1;
      end else if (rd_done) begin
        rd_act_r <= 1'b0;
      end
      if (wr_p & sel_cmd & ~bsy_r) begin
        case (addr)
          `ATATF_A_ERRFEAT: feat_r    <= dd_in[7:0];
          `ATATF_A_SECCNT:  seccnt_r  <= dd_in[7:0];
          `ATATF_A_SECNUM:  secnum_r  <= dd_in[7:0];
          `ATATF_A_CYLLO:   cyllo_r   <= dd_in[7:0];
          `ATATF_A_CYLHI:   cylhi_r   <= dd_in[7:0];
          `ATATF_A_DEVHEAD: devhead_r <= dd_in[7:0];
          default: ;
        endcase // [R3]
      end
      if (cmd_wr) begin
        cmd_code  <= dd_in[7:0];
        cmd_start <= 1'b1; // [R5]
        bsy_r     <= 1'b1;
        errf_r    <= 1'b0;
        drq_r     <= 1'b0;
        ptr_r     <= {BUF_AW{1'b0}};
      end else if (cmd_done) begin
        bsy_r  <= 1'b0;
        drq_r  <= 1'b0;
        errf_r <= cmd_err;
        err_r  <= cmd_err ? 8'h04 : 8'h00;
        pend_r <= 1'b1;
        if (cmd_code == `ATATF_CMD_CHKPWR) begin
          if (cmd_idle) begin
            seccnt_r <= `ATATF_PWR_IDLE; // [R17]
          end
        end else if (lba_mode) begin
          cylhi_r  <= cur_lba[23:16]; // [R8]
          cyllo_r  <= cur_lba[15:8]; // [R9]
          secnum_r <= cur_lba[7:0];
          devhead_r[3:0] <= cur_lba[27:24];
        end else begin
          cylhi_r  <= cur_cyl[15:8]; // [R7]
          cyllo_r  <= cur_cyl[7:0]; // [R7]
          devhead_r[3:0] <= cur_head;
        end
      end else if (xfer_req & ~drq_r) begin
        drq_r <= 1'b1; // [R22]
        bsy_r <= 1'b0;
      end else if (host_data_wr | rd_done) begin
        ptr_r <= ptr_r + {{(BUF_AW-1){1'b0}}, 1'b1};
        if (xfer_last) begin
          drq_r <= 1'b0; // [R22]
          bsy_r <= 1'b1;
        end
      end
      // Primary read clears; a same-cycle completion still wins
      if (stat_rd & ~cmd_done) begin
        pend_r <= 1'b0; // [R19]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and interrupt line
  reg [15:0] rd_nxt;
  reg        oe_nxt;
  always @* begin
    rd_nxt = 16'h0000;
    oe_nxt = 1'b0;
    if (~rd_n & sel_cmd) begin
      oe_nxt = 1'b1;
      if (bsy_r) begin
        rd_nxt = {8'h00, status};
      end else begin
        case (addr)
          `ATATF_A_DATA:    rd_nxt = drq_r ? (ecc_byte_mode ? {8'h00, buf_rd[7:0]} : buf_rd)
                                           : 16'h0000; // [R10] [R12]
          `ATATF_A_ERRFEAT: rd_nxt = {8'h00, err_r};
          `ATATF_A_SECCNT:  rd_nxt = {8'h00, seccnt_r};
          `ATATF_A_SECNUM:  rd_nxt = {8'h00, secnum_r};
          `ATATF_A_CYLLO:   rd_nxt = {8'h00, cyllo_r};
          `ATATF_A_CYLHI:   rd_nxt = {8'h00, cylhi_r};
          `ATATF_A_DEVHEAD: rd_nxt = {8'h00, devhead_r};
          default:          rd_nxt = {8'h00, status};
        endcase // [R3]
      end
    end else if (~rd_n & sel_ctl & addr[2] & addr[1]) begin
      oe_nxt = 1'b1;
      if (addr[0]) begin
        // Bit 7 left low; the far pin keeps it floating
        rd_nxt = {8'h00, 1'b0, 1'b1, ~devhead_r[3:0],
                  ~(dev_sel & DEV_ID), ~(dev_sel & ~DEV_ID)}; // [R2]
      end else begin
        rd_nxt = {8'h00, status}; // [R4] [R2]
      end
    end
    if (both_cs) begin
      oe_nxt = 1'b0; // [R23] [R1]
      rd_nxt = 16'h0000;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dd_out <= 16'h0000;
      dd_oe  <= 1'b0;
      intrq  <= 1'b0;
    end else begin
      dd_out <= rd_nxt;
      dd_oe  <= oe_nxt;
      intrq  <= pend_r & ~devctl_r[`ATATF_DC_NIEN] & dev_sel & ~in_reset; // [R16] [R20]
    end
  end
endmodule // atatf_port
`default_nettype wire

// ---- atatf_port_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module atatf_port_assertions (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        cs_cmd_n,
  input wire logic        cs_ctl_n,
  input wire logic [2:0]  addr,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [15:0] dd_in,
  input wire logic [15:0] dd_out,
  input wire logic        dd_oe,
  input wire logic        intrq,
  input wire logic        cmd_start,
  input wire logic [7:0]  cmd_code,
  input wire logic        in_reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire cmd_sel = !cs_cmd_n && cs_ctl_n;
  wire ctl_sel = cs_cmd_n && !cs_ctl_n;
  a_start_cause: assert property (cmd_start |-> $past(!wr_n && cmd_sel && addr == 3'h7))
    else $error("start without command write");
  a_start_code: assert property (cmd_start |-> cmd_code == $past(dd_in[7:0]))
    else $error("command code differs from bus");
  a_start_pulse: assert property (cmd_start |=> !cmd_start)
    else $error("start pulse too long");
  a_drive_select: assert property (dd_oe |-> $past(!rd_n && (cmd_sel || ctl_sel)))
    else $error("bus driven without single select");
  a_ctl_hole: assert property ($past(!rd_n && ctl_sel && addr[2:1] != 2'h3) |-> !dd_oe)
    else $error("empty control address driven");
  a_devaddr_read: assert property (
    $past(!rd_n && ctl_sel && addr == 3'h7) |-> dd_oe && !dd_out[7])
    else $error("device address read wrong");
  a_alt_keeps: assert property (intrq && !rd_n && ctl_sel && addr == 3'h6 |=> intrq)
    else $error("alternate read cleared interrupt");
  a_status_ack: assert property (
    intrq && !rd_n && cmd_sel && addr == 3'h7 |-> ##[1:4] !intrq)
    else $error("status read left interrupt");
  a_reset_quiet: assert property (in_reset |-> !cmd_start)
    else $error("command launched in reset");
  a_both_quiet: assert property ($past(!rd_n && !cs_cmd_n && !cs_ctl_n) |-> !dd_oe)
    else $error("bus driven with both selects");
endmodule // atatf_port_assertions
bind atatf_port atatf_port_assertions u_atatf_port_assertions (.ref_clk, .rst, .cs_cmd_n,
  .cs_ctl_n, .addr, .rd_n, .wr_n, .dd_in, .dd_out, .dd_oe, .intrq, .cmd_start, .cmd_code, .in_reset);
`default_nettype wire

// ---- atatf_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module atatf_host (
  input  wire logic        ref_clk,
  input  wire logic [15:0] dd_out,
  input  wire logic        dd_oe,
  output logic             cs_cmd_n,
  output logic             cs_ctl_n,
  output logic [2:0]       addr,
  output logic             rd_n,
  output logic             wr_n,
  output logic [15:0]      dd_in
);
  initial begin
    {cs_cmd_n, cs_ctl_n, rd_n, wr_n} = 4'hf;
    addr = 3'h0;
    dd_in = 16'h0000;
  end
  // Strobe low 4 edges, high 3: above the 3/2 cycle minimum
  task xfer(input [1:0] s, input [2:0] a, input w, input [15:0] d,
            output [15:0] q, output o);
    @(posedge ref_clk) #1;
    {cs_cmd_n, cs_ctl_n} = s;
    addr = a;
    dd_in = d;
    {rd_n, wr_n} = {w, !w};
    repeat (4) @(posedge ref_clk);
    #1;
    q = dd_out;
    o = dd_oe;
    {cs_cmd_n, cs_ctl_n, rd_n, wr_n} = 4'hf;
    // Released bus flips so stale write data cannot look valid
    dd_in = ~d;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule // atatf_host
`default_nettype wire

// ---- test_ata_task_file_register_port.sv ----
`include "atatf_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module test_ata_task_file_register_port;
  localparam logic [1:0] sel_c = 2'h1, sel_k = 2'h2;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hard_rst = 1'b0, cmd_done = 1'b0, cmd_idle = 1'b0, xfer_req = 1'b0;
  logic        cmd_err = 1'b0, xfer_last = 1'b0, xfer_dir_in = 1'b0, ecc_byte = 1'b0;
  logic        core_wr_en = 1'b0;
  logic [15:0] cur_cyl = 16'h0000, core_wr_data = 16'hbeef, q;
  logic [27:0] cur_lba = 28'h000_0000;
  logic [3:0]  cur_head = 4'h0;
  logic [7:0]  core_wr_addr = 8'h00, core_rd_addr = 8'h00, last_code = 8'h00;
  logic        o;
  wire         cs_cmd_n, cs_ctl_n, rd_n, wr_n, dd_oe, intrq, cmd_start, in_reset, ecc_byte_mode;
  wire  [2:0]  addr;
  wire  [15:0] dd_in, dd_out, core_rd_data;
  wire  [7:0]  cmd_code;
  integer      n_mismatch = 0, checks_done = 0, n_start = 0, i;
  always #2.5 ref_clk = ~ref_clk;
  // Launch pulse is one cycle, inside a host cycle
  always @(posedge ref_clk) if (cmd_start === 1'b1) begin
    n_start <= n_start + 1;
    last_code <= cmd_code;
  end
  atatf_port u_atatf_port (.ref_clk, .rst, .hard_rst, .cs_cmd_n, .cs_ctl_n, .addr, .rd_n,
    .wr_n, .dd_in, .dd_out, .dd_oe, .intrq, .cmd_start, .cmd_code, .in_reset, .ecc_byte_mode,
    .cmd_done, .cmd_err, .cmd_idle, .cur_cyl, .cur_lba, .cur_head, .xfer_req, .xfer_last,
    .xfer_dir_in, .ecc_byte, .core_wr_en, .core_wr_addr, .core_wr_data, .core_rd_addr,
    .core_rd_data);
  atatf_host u_atatf_host (.ref_clk, .dd_out, .dd_oe, .cs_cmd_n, .cs_ctl_n, .addr, .rd_n,
    .wr_n, .dd_in);
  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] e);
    checks_done = checks_done + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task rd(input [1:0] s, input [2:0] a);
    u_atatf_host.xfer(s, a, 1'b0, 16'h0000, q, o);
  endtask
  task rb(input [1:0] s, input [2:0] a, input [7:0] e);
    rd(s, a);
    chk({15'h0000, o}, 16'h0001);
    chk({8'h00, q[7:0]}, {8'h00, e});
  endtask
  task nd(input [1:0] s, input [2:0] a);
    rd(s, a);
    chk({15'h0000, o}, 16'h0000);
  endtask
  task wr(input [1:0] s, input [2:0] a, input [7:0] d);
    u_atatf_host.xfer(s, a, 1'b1, {8'h00, d}, q, o);
  endtask
  task cmd(input [7:0] c);
    i = n_start;
    wr(sel_c, 3'h7, c);
    chk(16'(n_start - i), 16'h0001);
    chk({8'h00, last_code}, {8'h00, c});
    @(posedge ref_clk) #1 cmd_done = 1'b1;
    @(posedge ref_clk) #1 cmd_done = 1'b0;
  endtask
  task irq_wait;
    for (i = 0; i < 8 && intrq !== 1'b1; i = i + 1) @(posedge ref_clk);
    chk({15'h0000, intrq}, 16'h0001);
    if (intrq !== 1'b1) end_of_test;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    rb(sel_c, 3'h1, 8'h01);
    rb(sel_c, 3'h2, 8'h01);
    rb(sel_c, 3'h3, 8'h01);
    rb(sel_c, 3'h6, 8'ha0);
    rb(sel_k, 3'h7, 8'h7e);
    rd(sel_k, 3'h6);
    rb(sel_c, 3'h7, q[7:0]);
    chk({15'h0000, q[3]}, 16'h0000);
    nd(sel_k, 3'h0);
    nd(sel_k, 3'h5);
    nd(2'h0, 3'h6);
    nd(2'h3, 3'h6);
    wr(sel_c, 3'h4, 8'h5a);
    wr(sel_c, 3'h5, 8'hc3);
    wr(2'h0, 3'h4, 8'h77);
    wr(2'h3, 3'h4, 8'h77);
    rb(sel_c, 3'h4, 8'h5a);
    rb(sel_c, 3'h5, 8'hc3);
    #1 cur_cyl = 16'h1234;
    cmd(8'h20);
    irq_wait;
    rb(sel_c, 3'h4, 8'h34);
    rb(sel_c, 3'h5, 8'h12);
    rd(sel_k, 3'h6);
    chk({15'h0000, intrq}, 16'h0001);
    rd(sel_c, 3'h7);
    chk({15'h0000, intrq}, 16'h0000);
    // Address mode set before the command byte
    wr(sel_c, 3'h6, 8'he0);
    #1 cur_lba = 28'h0ab_cdef;
    cmd(8'h20);
    irq_wait;
    rb(sel_c, 3'h4, 8'hcd);
    rb(sel_c, 3'h5, 8'hab);
    rd(sel_c, 3'h7);
    #1 cmd_idle = 1'b1;
    cmd(`ATATF_CMD_CHKPWR);
    irq_wait;
    rb(sel_c, 3'h2, 8'hff);
    rd(sel_c, 3'h7);
    // Other device selected: its pending interrupt stays off the line
    wr(sel_c, 3'h6, 8'hf0);
    cmd(8'h20);
    repeat (8) @(posedge ref_clk);
    chk({15'h0000, intrq}, 16'h0000);
    rb(sel_k, 3'h7, 8'h7f);
    wr(sel_c, 3'h6, 8'he0);
    chk({15'h0000, intrq}, 16'h0001);
    rd(sel_c, 3'h7);
    wr(sel_k, 3'h6, 8'h0a);
    cmd(8'h20);
    repeat (8) @(posedge ref_clk);
    chk({15'h0000, intrq}, 16'h0000);
    // Two buffered words; the second goes out as an ECC byte and ends the phase
    @(posedge ref_clk) #1 {core_wr_en, xfer_dir_in, xfer_req} = 3'h7;
    @(posedge ref_clk) #1 {core_wr_addr, core_wr_data, xfer_req} = {8'h01, 16'h5aa5, 1'b0};
    @(posedge ref_clk) #1 core_wr_en = 1'b0;
    rd(sel_c, 3'h7);
    chk({15'h0000, q[3]}, 16'h0001);
    rd(sel_c, 3'h0);
    chk(q, 16'hbeef);
    #1 {ecc_byte, xfer_last} = 2'h3;
    rd(sel_c, 3'h0);
    chk(q, 16'h00a5);
    rd(sel_c, 3'h7);
    chk({15'h0000, q[3]}, 16'h0000);
    wr(sel_k, 3'h6, 8'h0c);
    chk({15'h0000, in_reset}, 16'h0001);
    i = n_start;
    wr(sel_c, 3'h7, 8'h20);
    chk(16'(n_start - i), 16'h0000);
    repeat (`ATATF_SOFT_RESET_BIT_CYC) @(posedge ref_clk);
    wr(sel_k, 3'h6, 8'h08);
    chk({15'h0000, in_reset}, 16'h0000);
    wr(sel_c, 3'h2, 8'h33);
    @(posedge ref_clk) #1 hard_rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 hard_rst = 1'b0;
    chk({15'h0000, in_reset}, 16'h0001);
    // Hardware reset keeps device/head but restores the count register
    rb(sel_c, 3'h6, 8'he0);
    rb(sel_c, 3'h2, 8'h01);
    end_of_test;
  end
endmodule // test_ata_task_file_register_port
`default_nettype wire
